// [inc/ima_params.svh]
// Offsets, field positions, reset values and limits of the media access block.
// Assumes byte addresses on an 8-bit register address port.
`ifndef IMA_PARAMS_SVH
`define IMA_PARAMS_SVH
`define IMA_A_CTRL 8'h00
`define IMA_A_PERIOD 8'h04
`define IMA_A_SLOT 8'h08
`define IMA_A_IDS 8'h0c
`define IMA_A_USOFF 8'h10
`define IMA_A_GBOFF 8'h14
`define IMA_A_STATUS 8'h18
`define IMA_A_ISTAT 8'h1c
`define IMA_A_IMASK 8'h20
`define IMA_A_TIMER 8'h24
`define IMA_EN_BIT 8
`define IMA_HIGHEST_UNSCHEDULED_NODE_ID_LSB 8
`define IMA_PHASE_LSB 8
`define IMA_MOD_BIT 12
`define IMA_DUP_BIT 13
`define IMA_ROGUE_BIT 14
`define IMA_MISS_LSB 16
`define IMA_ID_RST 6'h3f
`define IMA_PERIOD_RST 20'h0c350
`define IMA_SLOT_RST 16'h0064
`define IMA_HIGHEST_SCHEDULED_NODE_ID_RST 6'h00
`define IMA_HIGHEST_UNSCHEDULED_NODE_ID_RST 6'h3f
`define IMA_USOFF_RST 20'h04e20
`define IMA_GBOFF_RST 20'h0afc8
`define IMA_MISS_LIMIT 2'h2
`endif

// [inc/ima_pkg.sv]
// Types of the implicit token media access block.
// Assumes nothing beyond a SystemVerilog compiler.
package ima_pkg;
  typedef enum logic [1:0] {
    PH_SCHED = 2'b00,
    PH_UNSCHED = 2'b01,
    PH_GUARD = 2'b10
  } ima_phase_type;
  typedef enum logic [2:0] {
    EV_NONE = 3'b000,
    EV_DUP_ID = 3'b001,
    EV_PAR_MISMATCH = 3'b010,
    EV_MOD_TAKE = 3'b011,
    EV_MOD_DROP = 3'b100,
    EV_MOD_LOST = 3'b101
  } ima_evt_type;
  typedef struct packed {
    logic [19:0] period;
    logic [15:0] slot;
    logic [5:0] highest_scheduled_node_id;
    logic [5:0] highest_unscheduled_node_id;
    logic [5:0] unscheduled_start_id;
  } ima_link_par_type;
  typedef struct packed {
    logic valid;
    ima_evt_type id;
    logic [5:0] info;
  } ima_notice_type;
  typedef struct packed {
    logic ctl_en;
    logic [5:0] own_id;
    ima_link_par_type cfg;
    ima_link_par_type publ;
    logic [19:0] us_off;
    logic [19:0] gb_off;
    logic [19:0] timer;
    ima_phase_type phase;
    logic [5:0] tok;
    logic [15:0] slot_cnt;
    logic carrier;
    logic tx_act;
    logic sent;
    logic dup;
    logic rogue;
    logic mod;
    logic mod_sent;
    logic [1:0] miss;
    logic [5:0] low_seen;
    logic low_valid;
    logic [4:0] istat;
    logic [4:0] imask;
    logic irq;
    logic [31:0] rdata;
    logic tx_start;
    logic tx_mod;
    ima_notice_type notice;
  } ima_state_type;
endpackage

// [logic/ima_media_access.sv]
// Implicit token medium access and moderator logic of one fieldbus node.
// Assumes a MAC that reports frame start and end with the source identifier,
// flags valid moderator frames, and sends a frame on a one-cycle start pulse.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "ima_params.svh"

// Behaviour
// - No transmit while cycle period disagrees.
// - Duplicate own identifier stops transmitting immediately.
// - Frame end loads token with source plus one.
// - Token equals own identifier: send one frame.
// - Frame or slot timeout advances token.
// - Slot timeout is a software adjustable count.
// - Cycle is scheduled, unscheduled, then guardband.
// - Scheduled pass runs zero to highest scheduled.
// - Unscheduled round robin up to guardband.
// - Unscheduled start rotates modulo highest plus one.
// - Unscheduled token wraps to zero past highest.
// - No ordinary frame starts that cannot end before guardband; moderator frames start in guardband.
// - Moderator frame in guardband resynchronises cycle.
// - Parameter mismatch on moderator frame disables transmitter.
// - Two silent cycles: lowest node becomes moderator.
// - Lower active identifier ends moderator role.
// - Event notices carry identifier plus optional information.
module ima_media_access (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic RX_START,
  input wire logic RX_END,
  input wire logic RX_MOD,
  input wire logic [5:0] RX_SRC,
  input wire ima_pkg::ima_link_par_type RX_PAR,
  input wire logic [15:0] TX_DUR,
  output logic TX_START,
  output logic TX_MOD_START,
  output ima_pkg::ima_link_par_type TX_PAR,
  output ima_pkg::ima_notice_type EVT,
  output logic IRQ
);
  import ima_pkg::*;

  ima_state_type s_q;
  ima_state_type s_d;
  logic wrap_c;
  logic mis_ev_c;
  logic dup_ev_c;
  logic drop_ev_c;
  logic lost_c;
  logic take_c;
  logic lowest_c;
  logic send_ok_c;
  logic slot_exp_c;
  logic elig_c;
  logic fits_c;
  logic [20:0] end_c;
  logic [4:0] set_c;
  logic [4:0] clr_c;
  logic [31:0] rd_c;

  // Next identifier; in the unscheduled interval it wraps past the highest one.
  function automatic logic [5:0] next_id(
    input logic [5:0] id,
    input logic [5:0] highest_unscheduled_node_id,
    input logic wrap
  );
    logic [5:0] n;
    n = 6'(id + 6'h01);
    if (wrap && id >= highest_unscheduled_node_id)
    begin
      n = 6'h00;
    end
    return n;
  endfunction

  always_comb
  begin
    s_d = s_q;
    s_d.tx_start = 1'b0;
    s_d.tx_mod = 1'b0;
    s_d.notice = '0;
    rd_c = 32'h0;
    clr_c = 5'h00;

    // A moderator frame restarts the cycle as well as the natural wrap does.
    wrap_c = RX_MOD || (s_q.timer >= 20'(s_q.cfg.period - 20'h00001));
    s_d.timer = wrap_c ? 20'h00000 : 20'(s_q.timer + 20'h00001);
    if (s_d.timer < s_q.us_off)
    begin
      s_d.phase = PH_SCHED;
    end
    else if (s_d.timer < s_q.gb_off)
    begin
      s_d.phase = PH_UNSCHED;
    end
    else
    begin
      s_d.phase = PH_GUARD;
    end

    mis_ev_c = RX_MOD && (RX_PAR.period != s_q.cfg.period
      || RX_PAR.slot != s_q.cfg.slot || RX_PAR.highest_scheduled_node_id != s_q.cfg.highest_scheduled_node_id
      || RX_PAR.highest_unscheduled_node_id != s_q.cfg.highest_unscheduled_node_id);
    dup_ev_c = RX_END && RX_SRC == s_q.own_id && !s_q.tx_act;
    drop_ev_c = s_q.mod && (RX_END || RX_MOD) && RX_SRC < s_q.own_id;
    lowest_c = !s_q.low_valid || s_q.own_id <= s_q.low_seen;
    lost_c = wrap_c && !RX_MOD && s_q.miss == 2'h1;
    take_c = lost_c && lowest_c && !s_q.mod;
    // Events of this very cycle already block a start; a flop would be a cycle late.
    send_ok_c = s_q.ctl_en && !s_q.dup && !s_q.rogue && !dup_ev_c && !mis_ev_c;
    slot_exp_c = !RX_END && !RX_START && !RX_MOD && !s_q.carrier && !s_q.tx_act
      && s_q.slot_cnt >= s_q.cfg.slot && s_q.phase != PH_GUARD;
    elig_c = (s_q.phase == PH_SCHED) ? (s_q.own_id <= s_q.cfg.highest_scheduled_node_id)
      : (s_q.own_id <= s_q.cfg.highest_unscheduled_node_id);
    end_c = {1'b0, s_q.timer} + {5'h00, TX_DUR};
    fits_c = end_c < {1'b0, s_q.gb_off};

    if (RX_START)
    begin
      s_d.carrier = 1'b1;
    end
    if (RX_END || RX_MOD)
    begin
      s_d.carrier = 1'b0;
      s_d.tx_act = 1'b0;
      if (!s_q.low_valid || RX_SRC < s_q.low_seen)
      begin
        s_d.low_seen = RX_SRC;
        s_d.low_valid = 1'b1;
      end
    end
    if (RX_START || RX_END || RX_MOD || slot_exp_c)
    begin
      s_d.slot_cnt = 16'h0000;
    end
    else if (s_q.slot_cnt != 16'hffff)
    begin
      s_d.slot_cnt = 16'(s_q.slot_cnt + 16'h0001);
    end

    case (s_q.phase)
      PH_SCHED, PH_UNSCHED:
      begin
        if (RX_END)
        begin
          s_d.tok = next_id(RX_SRC, s_q.cfg.highest_unscheduled_node_id, s_q.phase == PH_UNSCHED);
          s_d.sent = 1'b0;
        end
        else if (slot_exp_c)
        begin
          s_d.tok = next_id(s_q.tok, s_q.cfg.highest_unscheduled_node_id, s_q.phase == PH_UNSCHED);
        end
        if (s_q.tok == s_q.own_id && !s_q.sent && !s_q.tx_act && !s_q.carrier
          && !RX_START && !RX_END && elig_c && fits_c && send_ok_c)
        begin
          s_d.tx_start = 1'b1;
          s_d.sent = 1'b1;
          s_d.tx_act = 1'b1;
          s_d.slot_cnt = 16'h0000;
        end
      end
      PH_GUARD:
      begin
        // Ordinary frames never start here; only the moderator speaks.
        if (s_q.mod && !s_q.mod_sent && send_ok_c && !s_q.carrier
          && !s_q.tx_act && !RX_START)
        begin
          s_d.tx_mod = 1'b1;
          s_d.mod_sent = 1'b1;
          s_d.tx_act = 1'b1;
          s_d.publ = s_q.cfg;
          s_d.publ.unscheduled_start_id = next_id(s_q.cfg.unscheduled_start_id, s_q.cfg.highest_unscheduled_node_id, 1'b1);
        end
      end
      default:
      begin
        s_d.phase = PH_GUARD;
      end
    endcase

    if (s_q.phase == PH_SCHED && s_d.phase == PH_UNSCHED && !wrap_c)
    begin
      s_d.tok = s_q.cfg.unscheduled_start_id;
      s_d.sent = 1'b0;
      s_d.slot_cnt = 16'h0000;
    end

    if (wrap_c)
    begin
      s_d.tok = 6'h00;
      s_d.sent = 1'b0;
      s_d.mod_sent = 1'b0;
      s_d.low_valid = 1'b0;
      s_d.slot_cnt = 16'h0000;
      if (RX_MOD)
      begin
        s_d.miss = 2'h0;
        s_d.cfg.unscheduled_start_id = RX_PAR.unscheduled_start_id;
        s_d.rogue = mis_ev_c;
      end
      else
      begin
        // Without a moderator every node steps its start identifier alone.
        s_d.cfg.unscheduled_start_id = next_id(s_q.cfg.unscheduled_start_id, s_q.cfg.highest_unscheduled_node_id, 1'b1);
        if (s_q.miss != `IMA_MISS_LIMIT)
        begin
          s_d.miss = 2'(s_q.miss + 2'h1);
        end
      end
    end
    if (take_c)
    begin
      s_d.mod = 1'b1;
    end
    if (drop_ev_c)
    begin
      s_d.mod = 1'b0;
    end

    if (REG_WR)
    begin
      case (REG_ADDR)
        `IMA_A_CTRL:
        begin
          s_d.own_id = REG_WDATA[5:0];
          s_d.ctl_en = REG_WDATA[`IMA_EN_BIT];
          s_d.dup = 1'b0;
        end
        `IMA_A_PERIOD: s_d.cfg.period = REG_WDATA[19:0];
        `IMA_A_SLOT: s_d.cfg.slot = REG_WDATA[15:0];
        `IMA_A_IDS:
        begin
          s_d.cfg.highest_scheduled_node_id = REG_WDATA[5:0];
          s_d.cfg.highest_unscheduled_node_id = REG_WDATA[`IMA_HIGHEST_UNSCHEDULED_NODE_ID_LSB +: 6];
        end
        `IMA_A_USOFF: s_d.us_off = REG_WDATA[19:0];
        `IMA_A_GBOFF: s_d.gb_off = REG_WDATA[19:0];
        `IMA_A_ISTAT: clr_c = REG_WDATA[4:0];
        `IMA_A_IMASK: s_d.imask = REG_WDATA[4:0];
        default:
        begin
        end
      endcase
    end
    // The duplicate flag sets after any clear in the same cycle.
    if (dup_ev_c)
    begin
      s_d.dup = 1'b1;
    end

    set_c = {lost_c, drop_ev_c, take_c, mis_ev_c, dup_ev_c};
    s_d.istat = (s_q.istat & ~clr_c) | set_c;
    s_d.irq = |(s_d.istat & s_d.imask);

    if (dup_ev_c)
    begin
      s_d.notice = '{valid: 1'b1, id: EV_DUP_ID, info: RX_SRC};
    end
    else if (mis_ev_c)
    begin
      s_d.notice = '{valid: 1'b1, id: EV_PAR_MISMATCH, info: RX_SRC};
    end
    else if (drop_ev_c)
    begin
      s_d.notice = '{valid: 1'b1, id: EV_MOD_DROP, info: RX_SRC};
    end
    else if (take_c)
    begin
      s_d.notice = '{valid: 1'b1, id: EV_MOD_TAKE, info: s_q.own_id};
    end
    else if (lost_c)
    begin
      s_d.notice = '{valid: 1'b1, id: EV_MOD_LOST, info: 6'h00};
    end

    case (REG_ADDR)
      `IMA_A_CTRL:
      begin
        rd_c[5:0] = s_q.own_id;
        rd_c[`IMA_EN_BIT] = s_q.ctl_en;
      end
      `IMA_A_PERIOD: rd_c[19:0] = s_q.cfg.period;
      `IMA_A_SLOT: rd_c[15:0] = s_q.cfg.slot;
      `IMA_A_IDS:
      begin
        rd_c[5:0] = s_q.cfg.highest_scheduled_node_id;
        rd_c[`IMA_HIGHEST_UNSCHEDULED_NODE_ID_LSB +: 6] = s_q.cfg.highest_unscheduled_node_id;
      end
      `IMA_A_USOFF: rd_c[19:0] = s_q.us_off;
      `IMA_A_GBOFF: rd_c[19:0] = s_q.gb_off;
      `IMA_A_STATUS:
      begin
        rd_c[5:0] = s_q.tok;
        rd_c[`IMA_PHASE_LSB +: 2] = s_q.phase;
        rd_c[`IMA_MOD_BIT] = s_q.mod;
        rd_c[`IMA_DUP_BIT] = s_q.dup;
        rd_c[`IMA_ROGUE_BIT] = s_q.rogue;
        rd_c[`IMA_MISS_LSB +: 2] = s_q.miss;
      end
      `IMA_A_ISTAT: rd_c[4:0] = s_q.istat;
      `IMA_A_IMASK: rd_c[4:0] = s_q.imask;
      `IMA_A_TIMER: rd_c[19:0] = s_q.timer;
      default:
      begin
      end
    endcase
    s_d.rdata = REG_RD ? rd_c : 32'h0;
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q <= '0;
      s_q.own_id <= `IMA_ID_RST;
      s_q.cfg.period <= `IMA_PERIOD_RST;
      s_q.cfg.slot <= `IMA_SLOT_RST;
      s_q.cfg.highest_scheduled_node_id <= `IMA_HIGHEST_SCHEDULED_NODE_ID_RST;
      s_q.cfg.highest_unscheduled_node_id <= `IMA_HIGHEST_UNSCHEDULED_NODE_ID_RST;
      s_q.us_off <= `IMA_USOFF_RST;
      s_q.gb_off <= `IMA_GBOFF_RST;
      s_q.phase <= PH_SCHED;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign REG_RDATA = s_q.rdata;
  assign TX_START = s_q.tx_start;
  assign TX_MOD_START = s_q.tx_mod;
  assign TX_PAR = s_q.publ;
  assign EVT = s_q.notice;
  assign IRQ = s_q.irq;

  property p_tok_load;
    @(posedge CLK) disable iff (RST)
    (RX_END && s_q.phase == PH_SCHED && s_d.phase == PH_SCHED && !wrap_c)
    |=> s_q.tok == 6'($past(RX_SRC) + 6'h01);
  endproperty
  a_tok_load: assert property (p_tok_load)
    else $error("token not loaded from frame source");

  property p_dup_stop;
    @(posedge CLK) disable iff (RST)
    (dup_ev_c || s_q.dup) |=> !TX_START && !TX_MOD_START;
  endproperty
  a_dup_stop: assert property (p_dup_stop)
    else $error("transmit after duplicate identifier");

  property p_own_turn;
    @(posedge CLK) disable iff (RST)
    TX_START |-> $past(s_q.tok) == $past(s_q.own_id) && !$past(s_q.sent);
  endproperty
  a_own_turn: assert property (p_own_turn)
    else $error("frame started without own token");

  property p_guard_quiet;
    @(posedge CLK) disable iff (RST)
    TX_START |-> $past(s_q.phase) != PH_GUARD && $past(fits_c);
  endproperty
  a_guard_quiet: assert property (p_guard_quiet)
    else $error("frame started that cannot end before guardband");

  property p_slot_adv;
    @(posedge CLK) disable iff (RST)
    (slot_exp_c && s_q.phase == PH_SCHED && s_d.phase == PH_SCHED && !wrap_c)
    |=> s_q.tok == 6'($past(s_q.tok) + 6'h01) && s_q.slot_cnt == 16'h0000;
  endproperty
  a_slot_adv: assert property (p_slot_adv)
    else $error("token not advanced on slot timeout");

  property p_resync;
    @(posedge CLK) disable iff (RST)
    RX_MOD |=> s_q.timer == 20'h00000 ##1 s_q.timer == 20'h00001 || wrap_c;
  endproperty
  a_resync: assert property (p_resync)
    else $error("cycle timer not restarted by moderator frame");

  property p_period_off;
    @(posedge CLK) disable iff (RST)
    (RX_MOD && RX_PAR.period != s_q.cfg.period) |=> s_q.rogue && !TX_START;
  endproperty
  a_period_off: assert property (p_period_off)
    else $error("transmitter live with foreign cycle period");

  property p_mismatch;
    @(posedge CLK) disable iff (RST)
    (RX_MOD && RX_PAR.slot != s_q.cfg.slot) |=> s_q.rogue ##1 !TX_START;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("parameter mismatch did not disable transmitter");

  property p_mod_drop;
    @(posedge CLK) disable iff (RST)
    drop_ev_c |=> !s_q.mod && EVT.valid && EVT.id == EV_MOD_DROP;
  endproperty
  a_mod_drop: assert property (p_mod_drop)
    else $error("moderator role kept beside lower identifier");
endmodule

// [testbench/ima_far_nodes.sv]
// Model of the other link nodes and the medium as the MAC reports them.
// Assumes one frame in flight; the bench asks for foreign frames by pulse.
`timescale 1ns/1ps
module ima_far_nodes (
  input wire logic CLK,
  input wire logic RST,
  input wire logic TX_START,
  input wire logic TX_MOD_START,
  input wire ima_pkg::ima_link_par_type TX_PAR,
  input wire logic [5:0] OWN_ID,
  input wire logic [7:0] DLY,
  input wire logic INJ_END,
  input wire logic INJ_MOD,
  input wire logic [5:0] INJ_SRC,
  input wire ima_pkg::ima_link_par_type INJ_PAR,
  output logic RX_START,
  output logic RX_END,
  output logic RX_MOD,
  output logic [5:0] RX_SRC,
  output ima_pkg::ima_link_par_type RX_PAR
);
  import ima_pkg::*;
  logic [7:0] cnt_q;
  logic mod_q;
  logic [5:0] src_q;
  ima_link_par_type par_q;
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cnt_q <= 8'h00;
      mod_q <= 1'b0;
      src_q <= 6'h00;
      par_q <= '0;
      RX_START <= 1'b0;
      RX_END <= 1'b0;
      RX_MOD <= 1'b0;
      RX_SRC <= 6'h00;
      RX_PAR <= '0;
    end
    else
    begin
      RX_START <= 1'b0;
      RX_END <= 1'b0;
      RX_MOD <= 1'b0;
      // Released lines show the inverse so that a stale source is never mistaken for valid.
      RX_SRC <= ~src_q;
      RX_PAR <= ima_link_par_type'(~par_q);
      if (TX_START || TX_MOD_START || INJ_END || INJ_MOD)
      begin
        // The medium echoes own frames back, so they end with the node's own source.
        RX_START <= 1'b1;
        cnt_q <= DLY;
        mod_q <= TX_MOD_START || INJ_MOD;
        src_q <= (INJ_END || INJ_MOD) ? INJ_SRC : OWN_ID;
        par_q <= INJ_MOD ? INJ_PAR : TX_PAR;
      end
      else if (cnt_q == 8'h01)
      begin
        RX_END <= !mod_q;
        RX_MOD <= mod_q;
        RX_SRC <= src_q;
        RX_PAR <= par_q;
        cnt_q <= 8'h00;
      end
      else if (cnt_q != 8'h00)
      begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule

// [testbench/testbench.sv]
// Self-checking bench of the implicit token media access block.
// Assumes the far-node model echoes own frames and injects foreign ones.
`timescale 1ns/1ps
`include "ima_params.svh"
module testbench;
  import ima_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic rx_start, rx_end, rx_mod, tx_start, tx_mod_start, irq;
  logic [5:0] rx_src;
  logic [5:0] inj_src = 6'h00;
  logic inj_end = 1'b0;
  logic inj_mod = 1'b0;
  logic [15:0] tx_dur = 16'h0004;
  logic [7:0] far_dly = 8'h03;
  ima_link_par_type rx_par, tx_par;
  ima_link_par_type inj_par = '0;
  ima_link_par_type cfg = '{20'h00190, 16'h0028, 6'h05, 6'h07, 6'h06};
  ima_notice_type evt;
  ima_notice_type last_evt = '0;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int tx_cnt = 0;
  int mod_cnt = 0;

  always #5 clk = ~clk;

  ima_media_access DUT (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .RX_START(rx_start),
    .RX_END(rx_end), .RX_MOD(rx_mod), .RX_SRC(rx_src), .RX_PAR(rx_par), .TX_DUR(tx_dur),
    .TX_START(tx_start), .TX_MOD_START(tx_mod_start), .TX_PAR(tx_par), .EVT(evt), .IRQ(irq));

  ima_far_nodes far (.CLK(clk), .RST(rst), .TX_START(tx_start), .TX_MOD_START(tx_mod_start),
    .TX_PAR(tx_par), .OWN_ID(6'h03), .DLY(far_dly), .INJ_END(inj_end), .INJ_MOD(inj_mod),
    .INJ_SRC(inj_src), .INJ_PAR(inj_par), .RX_START(rx_start), .RX_END(rx_end),
    .RX_MOD(rx_mod), .RX_SRC(rx_src), .RX_PAR(rx_par));

  // Pulses last one cycle, so they are caught here rather than by the scenarios.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (evt.valid === 1'b1) last_evt <= evt;
    if (tx_start === 1'b1) tx_cnt <= tx_cnt + 1;
    if (tx_mod_start === 1'b1) mod_cnt <= mod_cnt + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // One idle edge keeps the strobe from being lowered and raised in one time step.
    @(posedge clk);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
    if (m != 32'h0) chk(d & m, e);
  endtask

  // Polls the cycle timer; a miss after two cycles' worth of reads is a mismatch.
  task automatic wait_t(input int t);
    for (int i = 0; i < 400; i++)
    begin
      rc(`IMA_A_TIMER, 32'h0, 32'h0);
      if (d[19:0] >= t && d[19:0] < t + 8) return;
    end
    chk(d, t);
  endtask

  task automatic inj(input logic m, input logic [5:0] s, input ima_link_par_type p);
    inj_src <= s;
    inj_par <= p;
    inj_mod <= m;
    inj_end <= !m;
    @(posedge clk);
    inj_mod <= 1'b0;
    inj_end <= 1'b0;
    repeat (far_dly + 3) @(posedge clk);
  endtask

  task automatic resync();
    repeat (12) @(posedge clk);
    inj(1'b1, 6'h00, cfg);
  endtask

  task automatic t_reset();
    rc(`IMA_A_CTRL, 32'h1ff, 32'h03f);
    rc(`IMA_A_PERIOD, 32'hfffff, `IMA_PERIOD_RST);
    rc(`IMA_A_SLOT, 32'hffffffff, `IMA_SLOT_RST);
    rc(`IMA_A_IDS, 32'hffffffff, 32'h3f00);
    rc(`IMA_A_USOFF, 32'hffffffff, `IMA_USOFF_RST);
    rc(`IMA_A_GBOFF, 32'hffffffff, `IMA_GBOFF_RST);
    rc(`IMA_A_STATUS, 32'hffffffff, 32'h0);
    rc(8'h30, 32'hffffffff, 32'h0);
  endtask

  task automatic t_config();
    wr(`IMA_A_PERIOD, 32'h190);
    wr(`IMA_A_SLOT, 32'h28);
    wr(`IMA_A_IDS, 32'h0705);
    wr(`IMA_A_USOFF, 32'h96);
    wr(`IMA_A_GBOFF, 32'h12c);
    wr(`IMA_A_CTRL, 32'h103);
    rc(`IMA_A_SLOT, 32'hffffffff, 32'h28);
    rc(`IMA_A_IDS, 32'hffffffff, 32'h0705);
  endtask

  task automatic t_token();
    int n;
    resync();
    n = tx_cnt;
    inj(1'b0, 6'h02, cfg);
    repeat (8) @(posedge clk);
    chk(tx_cnt, n + 1);
    rc(`IMA_A_STATUS, 32'h3f, 32'h04);
    repeat (45) @(posedge clk);
    rc(`IMA_A_STATUS, 32'h3f, 32'h05);
  endtask

  task automatic t_fit();
    int n;
    tx_dur <= 16'h1000;
    resync();
    n = tx_cnt;
    inj(1'b0, 6'h02, cfg);
    repeat (10) @(posedge clk);
    chk(tx_cnt, n);
    rc(`IMA_A_STATUS, 32'h3f, 32'h03);
    tx_dur <= 16'h0004;
  endtask

  task automatic t_cycle();
    wr(`IMA_A_ISTAT, 32'h1f);
    resync();
    wait_t(60);
    rc(`IMA_A_STATUS, 32'h300, 32'h000);
    wait_t(155);
    rc(`IMA_A_STATUS, 32'h33f, 32'h106);
    inj(1'b0, 6'h07, cfg);
    rc(`IMA_A_STATUS, 32'h3f, 32'h00);
    wait_t(305);
    rc(`IMA_A_STATUS, 32'h300, 32'h200);
    wait_t(155);
    rc(`IMA_A_STATUS, 32'h3f, 32'h07);
    wait_t(305);
    wait_t(155);
    rc(`IMA_A_STATUS, 32'h133f, 32'h1100);
    rc(`IMA_A_ISTAT, 32'h14, 32'h14);
    for (int i = 0; i < 300 && mod_cnt == 0; i++) @(posedge clk);
    chk(mod_cnt, 1);
    chk({tx_par.period, tx_par.highest_scheduled_node_id, tx_par.highest_unscheduled_node_id}, {20'h190, 6'h05, 6'h07});
    chk(tx_par.unscheduled_start_id, 6'h01);
    wr(`IMA_A_IMASK, 32'h04);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    wr(`IMA_A_ISTAT, 32'h04);
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
  endtask

  task automatic t_drop();
    inj(1'b0, 6'h01, cfg);
    rc(`IMA_A_STATUS, 32'h1000, 32'h0);
    chk({last_evt.id, last_evt.info}, {EV_MOD_DROP, 6'h01});
  endtask

  task automatic t_dup();
    int n;
    resync();
    inj(1'b0, 6'h03, cfg);
    chk({last_evt.id, last_evt.info}, {EV_DUP_ID, 6'h03});
    rc(`IMA_A_STATUS, 32'h203f, 32'h2004);
    n = tx_cnt;
    inj(1'b0, 6'h02, cfg);
    repeat (10) @(posedge clk);
    chk(tx_cnt, n);
    wr(`IMA_A_CTRL, 32'h103);
    rc(`IMA_A_STATUS, 32'h2000, 32'h0);
  endtask

  task automatic t_rogue();
    int n;
    ima_link_par_type p;
    p = cfg;
    p.period = 20'h00191;
    p.slot = 16'h0029;
    repeat (12) @(posedge clk);
    inj(1'b1, 6'h00, p);
    chk({last_evt.id, last_evt.info}, {EV_PAR_MISMATCH, 6'h00});
    rc(`IMA_A_STATUS, 32'h4000, 32'h4000);
    n = tx_cnt;
    inj(1'b0, 6'h02, cfg);
    repeat (10) @(posedge clk);
    chk(tx_cnt, n);
    resync();
    rc(`IMA_A_STATUS, 32'h4000, 32'h0);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_config();
    t_token();
    t_fit();
    t_cycle();
    t_drop();
    t_dup();
    t_rogue();
    summarize();
  end
endmodule
